// ==== include/ustf_defines.vh ====
// Register map, field positions, reset values and timing counts of the UART status flag block
// Behaviour
// - Complete flag set at reset, when idle
// - Complete clears on data, preamble, break
// - Complete reads 0 while transmitter busy
// - Receive full bit 5 set on load
// - Receive full clears by status, data read
// - IDLE bit 4 set after character-time high
// - Idle time is 10 or 11 bits
// - Clear count bit: count after start bit
// - Set count bit: count after stop bits
// - IDLE clears by reads, rearms on character
// - IDLE raised once per idle period
`ifndef USTF_DEFINES_VH
`define USTF_DEFINES_VH

// Byte addresses on the APB
`define USTF_ADDR_W 8
`define USTF_OFS_CTRL1 8'h00
`define USTF_OFS_STATUS 8'h04
`define USTF_OFS_CTRL2 8'h08
`define USTF_OFS_DATA 8'h0C
`define USTF_OFS_IRQ_STAT 8'h10
`define USTF_OFS_IRQ_MASK 8'h14

// Line status register fields
`define USTF_ST_TX_EMPTY 7
`define USTF_ST_TX_DONE 6
`define USTF_ST_RX_FULL 5
`define USTF_ST_IDLE 4

// First control register fields
`define USTF_CR1_LONG_FRAME 4
`define USTF_CR1_IDLE_AFTER_STOP 2

// Second control register fields
`define USTF_C2_TX_ON 3
`define USTF_C2_BREAK 0

// Interrupt status and mask fields
`define USTF_IRQ_TX_DONE 0
`define USTF_IRQ_RX_FULL 1
`define USTF_IRQ_IDLE 2
`define USTF_IRQ_W 3

// Reset values
`define USTF_RST_CTRL1 8'h00
`define USTF_RST_CTRL2 8'h00
`define USTF_RST_IRQ_MASK 3'h0

// Idle character time in bit times
`define USTF_IDLE_BITS_SHORT 4'hA
`define USTF_IDLE_BITS_LONG 4'hB

`endif

// ==== rtl/ustf_idle_det.v ====
// Idle-line detector: counts high bit times on the receive line
`timescale 1ns/10ps
`default_nettype none
`include "ustf_defines.vh"
module ustf_idle_det (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Receive line and bit timebase
  input wire line_i,
  input wire tick_i,
  input wire start_i,
  input wire stop_i,
  input wire char_i,
  // Configuration
  input wire after_stop_i,
  input wire long_frame_i,
  // One-cycle idle event
  output reg idle_o
);
  reg [3:0] cnt;
  reg counting;
  reg armed;
  wire [3:0] target;
  wire [3:0] cnt_inc;

  assign target = long_frame_i ? `USTF_IDLE_BITS_LONG : `USTF_IDLE_BITS_SHORT;
  assign cnt_inc = cnt + 4'h1;

  // Counting window, count of high bit times and one-shot arming
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      counting <= 1'b0;
      armed <= 1'b0;
      idle_o <= 1'b0;
    end else begin
      idle_o <= 1'b0;
      if (start_i) begin
        cnt <= 4'h0;
        counting <= !after_stop_i;
      end else if (stop_i && after_stop_i) begin
        cnt <= 4'h0;
        counting <= 1'b1;
      end else if (tick_i && counting) begin
        if (!line_i) begin
          cnt <= 4'h0;
        end else if (cnt_inc == target) begin
          // Stop counting so a long idle line cannot raise a second event
          counting <= 1'b0;
          cnt <= 4'h0;
          if (armed) begin
            idle_o <= 1'b1;
            armed <= 1'b0;
          end
        end else begin
          cnt <= cnt_inc;
        end
      end
      // A new character rearms; set wins over the disarm above
      if (char_i) begin
        armed <= 1'b1;
      end
    end
  end
endmodule // ustf_idle_det
`default_nettype wire

// ==== rtl/ustf_sync2.v ====
// Two flip-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module ustf_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Asynchronous level in, synchronised level out
  input wire async_i,
  output wire sync_o
);
  reg stage1;
  reg stage2;

  // Stage one feeds stage two only, to let metastability settle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      if (RESET_VAL) begin
        stage1 <= 1'b1;
        stage2 <= 1'b1;
      end
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule // ustf_sync2
`default_nettype wire

// ==== rtl/ustf_top.v ====
// UART status flags: transmit complete, receive full and idle line, behind an APB slave
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ustf_defines.vh"
module ustf_top (
  // Clock and reset
  input wire CLK_I,
  input wire RESET_N_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [`USTF_ADDR_W-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // Transmit shifter side
  input wire TX_LOAD_I,
  input wire TX_BUSY_I,
  output reg [7:0] TX_DATA_O,
  output reg TX_FULL_O,
  output reg TX_PREAMBLE_O,
  output reg TX_BREAK_O,
  // Receive shifter side
  input wire BIT_TICK_I,
  input wire RX_START_I,
  input wire RX_STOP_I,
  input wire RX_LOAD_I,
  input wire [7:0] RX_DATA_I,
  input wire RXD_I,
  // Interrupt
  output reg IRQ_O
);
  // Reset synchroniser: asserts at once, releases after two edges
  reg rst_meta;
  reg rst_n;

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Flag life cycle, as software sees it through the line status register:
  //   tx_empty    - set at reset and when the shifter takes the buffer;
  //                 a data write clears it only after a status read saw it set
  //   tx_complete - set at reset and when the transmitter falls idle with an
  //                 empty buffer; forced low while the shifter is busy
  //   rx_full     - set when a character lands in the receive data register
  //   idle        - set once per idle period after a received character
  // Every clear except the busy force needs a status read that returned the flag set, followed by
  // the matching data access, or a preamble or break write for tx_complete. The pending read is kept per flag, so a flag
  // that rises after the status read cannot be cleared by accident.

  // Flags and registers
  reg tx_empty;
  reg tx_complete;
  reg rx_full;
  reg idle;
  reg seen_tx_empty;
  reg seen_tx_complete;
  reg seen_rx_full;
  reg seen_idle;
  reg [7:0] ctrl1;
  reg [7:0] ctrl2;
  reg [7:0] rx_data;
  reg [`USTF_IRQ_W-1:0] irq_stat;
  reg [`USTF_IRQ_W-1:0] irq_mask;
  reg [7:0] status_snap;
  reg tx_done_prev;

  wire rxd_sync;
  wire idle_event;

  // Receive pin crosses into the clock domain; idle level is high
  ustf_sync2 #(
    .RESET_VAL(1'b1)
  ) u_rxd_sync (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .async_i(RXD_I),
    .sync_o(rxd_sync)
  );

  ustf_idle_det u_idle_det (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .line_i(rxd_sync),
    .tick_i(BIT_TICK_I),
    .start_i(RX_START_I),
    .stop_i(RX_STOP_I),
    .char_i(RX_LOAD_I),
    .after_stop_i(ctrl1[`USTF_CR1_IDLE_AFTER_STOP]),
    .long_frame_i(ctrl1[`USTF_CR1_LONG_FRAME]),
    .idle_o(idle_event)
  );

  // Status register image; bits this block does not hold read as zero
  function [7:0] status_word;
    input f_tx_empty;
    input f_tx_complete;
    input f_rx_full;
    input f_idle;
    begin
      status_word = 8'h00;
      status_word[`USTF_ST_TX_EMPTY] = f_tx_empty;
      status_word[`USTF_ST_TX_DONE] = f_tx_complete;
      status_word[`USTF_ST_RX_FULL] = f_rx_full;
      status_word[`USTF_ST_IDLE] = f_idle;
    end
  endfunction

  // Address decode, used only in the setup cycle to set the error flag
  function mapped;
    input [`USTF_ADDR_W-1:0] a;
    begin
      mapped = (a == `USTF_OFS_CTRL1) || (a == `USTF_OFS_STATUS) ||
               (a == `USTF_OFS_CTRL2) || (a == `USTF_OFS_DATA) ||
               (a == `USTF_OFS_IRQ_STAT) || (a == `USTF_OFS_IRQ_MASK);
    end
  endfunction

  // Bus phases: setup captures read data, access edge carries side effects.
  // Side effects wait for the access edge, so a transfer that is still in
  // its setup cycle leaves every flag and pending read untouched.
  wire setup = PSEL_I && !PENABLE_I;
  wire access = PSEL_I && PENABLE_I && PREADY_O;
  wire wr = access && PWRITE_I;
  wire rd = access && !PWRITE_I;
  wire wr_data = wr && (PADDR_I == `USTF_OFS_DATA);
  wire wr_ctrl2 = wr && (PADDR_I == `USTF_OFS_CTRL2);
  wire rd_status = rd && (PADDR_I == `USTF_OFS_STATUS);
  wire rd_data = rd && (PADDR_I == `USTF_OFS_DATA);
  wire rd_irq = rd && (PADDR_I == `USTF_OFS_IRQ_STAT);

  // Transmit-side events
  // Only a 0 to 1 change of tx_on queues a preamble; rewriting a set bit
  // queues nothing and so clears nothing.
  wire tx_on_rise = wr_ctrl2 && PWDATA_I[`USTF_C2_TX_ON] && !ctrl2[`USTF_C2_TX_ON];
  wire break_write = wr_ctrl2 && PWDATA_I[`USTF_C2_BREAK];
  wire tx_done = tx_empty && !TX_BUSY_I;
  wire done_set = tx_done && !tx_done_prev;
  wire done_clr = seen_tx_complete && (wr_data || tx_on_rise || break_write);

  // APB handshake: one wait state, so every answer comes from a flip-flop.
  // The status image is frozen in the setup cycle; the pending reads are
  // taken from that frozen copy, so software clears exactly what it saw.
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      status_snap <= 8'h00;
    end else begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      if (setup) begin
        PSLVERR_O <= !mapped(PADDR_I);
        status_snap <= status_word(tx_empty, tx_complete, rx_full, idle);
        case (PADDR_I)
          `USTF_OFS_CTRL1: PRDATA_O <= {24'h00_0000, ctrl1};
          `USTF_OFS_STATUS: PRDATA_O <= {24'h00_0000,
                                         status_word(tx_empty, tx_complete, rx_full, idle)};
          `USTF_OFS_CTRL2: PRDATA_O <= {24'h00_0000, ctrl2};
          `USTF_OFS_DATA: PRDATA_O <= {24'h00_0000, rx_data};
          `USTF_OFS_IRQ_STAT: PRDATA_O <= {29'h0000_0000, irq_stat};
          `USTF_OFS_IRQ_MASK: PRDATA_O <= {29'h0000_0000, irq_mask};
          default: PRDATA_O <= 32'h0000_0000;
        endcase
      end else if (access) begin
        PSLVERR_O <= 1'b0;
      end
    end
  end

  // Control registers; status offset ignores writes
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1 <= `USTF_RST_CTRL1;
      ctrl2 <= `USTF_RST_CTRL2;
      irq_mask <= `USTF_RST_IRQ_MASK;
      TX_DATA_O <= 8'h00;
    end else if (wr) begin
      case (PADDR_I)
        `USTF_OFS_CTRL1: ctrl1 <= PWDATA_I[7:0];
        `USTF_OFS_CTRL2: ctrl2 <= PWDATA_I[7:0];
        `USTF_OFS_DATA: TX_DATA_O <= PWDATA_I[7:0];
        `USTF_OFS_IRQ_MASK: irq_mask <= PWDATA_I[`USTF_IRQ_W-1:0];
        default: ctrl1 <= ctrl1;
      endcase
    end
  end

  // Transmit side: buffer flag, complete flag and shifter requests.
  // Limitation: the complete flag only sets on the idle edge, so a preamble
  // or break that the shifter never starts leaves it low until the shifter
  // has run once more.
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty <= 1'b1;
      tx_complete <= 1'b1;
      tx_done_prev <= 1'b1;
      TX_FULL_O <= 1'b0;
      TX_PREAMBLE_O <= 1'b0;
      TX_BREAK_O <= 1'b0;
    end else begin
      tx_done_prev <= tx_done;
      // Shifter taking the buffer wins over a clearing write
      if (TX_LOAD_I) begin
        tx_empty <= 1'b1;
      end else if (wr_data && seen_tx_empty) begin
        tx_empty <= 1'b0;
      end
      if (TX_LOAD_I) begin
        TX_FULL_O <= 1'b0;
      end else if (wr_data) begin
        TX_FULL_O <= 1'b1;
      end
      // Busy forces zero; the idle edge sets and beats a clear
      if (TX_BUSY_I) begin
        tx_complete <= 1'b0;
      end else if (done_set) begin
        tx_complete <= 1'b1;
      end else if (done_clr) begin
        tx_complete <= 1'b0;
      end
      TX_PREAMBLE_O <= tx_on_rise;
      if (wr_ctrl2) begin
        TX_BREAK_O <= PWDATA_I[`USTF_C2_BREAK];
      end
    end
  end

  // Receive side: data register, full flag and idle flag.
  // A new character wins over a clearing data read in the same cycle, so a
  // character can never land unannounced.
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      idle <= 1'b0;
    end else begin
      if (RX_LOAD_I) begin
        rx_data <= RX_DATA_I;
      end
      if (RX_LOAD_I) begin
        rx_full <= 1'b1;
      end else if (rd_data && seen_rx_full) begin
        rx_full <= 1'b0;
      end
      if (idle_event) begin
        idle <= 1'b1;
      end else if (rd_data && seen_idle) begin
        idle <= 1'b0;
      end
    end
  end

  // Pending status reads, one per flag, consumed by the matching data access.
  // A fresh status read replaces all four, so a stale read cannot linger
  // behind a newer one that saw the flag low.
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      seen_tx_empty <= 1'b0;
      seen_tx_complete <= 1'b0;
      seen_rx_full <= 1'b0;
      seen_idle <= 1'b0;
    end else begin
      if (rd_status) begin
        seen_tx_empty <= status_snap[`USTF_ST_TX_EMPTY];
        seen_tx_complete <= status_snap[`USTF_ST_TX_DONE];
        seen_rx_full <= status_snap[`USTF_ST_RX_FULL];
        seen_idle <= status_snap[`USTF_ST_IDLE];
      end else begin
        // Each data access uses up only its own pending reads
        if (wr_data) begin
          seen_tx_empty <= 1'b0;
        end
        if (done_clr) begin
          seen_tx_complete <= 1'b0;
        end
        if (rd_data) begin
          seen_rx_full <= 1'b0;
          seen_idle <= 1'b0;
        end
      end
    end
  end

  // Sticky events; a read clears only what it returned, so a new set survives.
  // The interrupt output lags the status by one cycle because it comes
  // straight from a flip-flop.
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 3'h0;
      IRQ_O <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(rd_irq ? PRDATA_O[`USTF_IRQ_W-1:0] : 3'h0)) |
                  {idle_event, RX_LOAD_I, done_set};
      IRQ_O <= |(irq_stat & irq_mask);
    end
  end
endmodule // ustf_top
`default_nettype wire

// ==== test/ustf_monitor.sv ====
// Port-level assertion checker for the UART status flag block
`timescale 1ns/10ps
`default_nettype none
`include "ustf_defines.vh"
module ustf_monitor (
  // Clock, reset and APB
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`USTF_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Transmit side
  input wire logic TX_BUSY_I,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_FULL_O,
  input wire logic TX_PREAMBLE_O,
  input wire logic TX_BREAK_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic done;
  logic on_q;
  // Completed access
  assign done = PSEL_I && PENABLE_I && PREADY_O;
  // Shadow of tx_on, so only a 0 to 1 change is expected to queue a preamble
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      on_q <= 1'b0;
    end else if (done && PWRITE_I && PADDR_I == `USTF_OFS_CTRL2) begin
      on_q <= PWDATA_I[`USTF_C2_TX_ON];
    end
  end
  a_ready_wait: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I)
    |-> !PREADY_O ##1 PREADY_O) else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
  a_err_unmapped: assert property (done && PADDR_I > 8'h14 |-> PSLVERR_O)
    else $error("unmapped access without error");
  a_err_mapped: assert property (done && PADDR_I <= 8'h14 && PADDR_I[1:0] == 2'b00
    |-> !PSLVERR_O) else $error("mapped access with error");
  a_preamble_on: assert property (done && PWRITE_I && PADDR_I == `USTF_OFS_CTRL2
    && PWDATA_I[3] && !on_q |=> TX_PREAMBLE_O) else $error("no preamble");
  a_preamble_once: assert property (TX_PREAMBLE_O |=> !TX_PREAMBLE_O)
    else $error("preamble longer than a cycle");
  a_break_copy: assert property (done && PWRITE_I && PADDR_I == `USTF_OFS_CTRL2
    |=> TX_BREAK_O == $past(PWDATA_I[0])) else $error("break bit not copied");
  a_data_load: assert property (done && PWRITE_I && PADDR_I == `USTF_OFS_DATA
    |=> TX_FULL_O && TX_DATA_O == $past(PWDATA_I[7:0])) else $error("tx data lost");
  a_tc_busy: assert property (done && !PWRITE_I && PADDR_I == `USTF_OFS_STATUS
    && $past(TX_BUSY_I, 2) && $past(TX_BUSY_I, 3) && $past(TX_BUSY_I, 4)
    |-> !PRDATA_O[6]) else $error("complete flag set while busy");
endmodule // ustf_monitor
bind ustf_top ustf_monitor i_mon (.CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .TX_BUSY_I, .TX_DATA_O,
  .TX_FULL_O, .TX_PREAMBLE_O, .TX_BREAK_O);
`default_nettype wire

// ==== test/ustf_tb_top.sv ====
// Self-checking bench for the UART status flag block
`timescale 1ns/10ps
`default_nettype none
`include "ustf_defines.vh"
module ustf_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 0, pen = 0, pwr = 0, err;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, tx_full, tx_pre, tx_brk, irq;
  logic [7:0] tx_data;
  logic [7:0] rx_data = 8'h00;
  logic rxd = 1'b1;
  logic tx_load = 0, busy = 0, tick = 0, rx_start = 0, rx_stop = 0, rx_load = 0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  ustf_top i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TX_LOAD_I(tx_load), .TX_BUSY_I(busy),
    .TX_DATA_O(tx_data), .TX_FULL_O(tx_full), .TX_PREAMBLE_O(tx_pre),
    .TX_BREAK_O(tx_brk), .BIT_TICK_I(tick), .RX_START_I(rx_start), .RX_STOP_I(rx_stop),
    .RX_LOAD_I(rx_load), .RX_DATA_I(rx_data), .RXD_I(rxd), .IRQ_O(irq));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A hang would otherwise run forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ld;
    rx_load <= 1'b1;
    step(1);
    rx_load <= 1'b0;
    step(1);
  endtask
  task automatic tk;
    tick <= 1'b1;
    step(1);
    tick <= 1'b0;
    step(1);
  endtask
  task automatic t_reset;
    rd(`USTF_OFS_STATUS);
    chk("status", rv, 32'h0000_00C0);
    rd(`USTF_OFS_CTRL1);
    chk("ctrl1", rv, 32'h0000_0000);
    rd(8'h20);
    chk("unmapped", {rv[30:0], err}, 32'h0000_0001);
  endtask
  task automatic t_tx;
    rd(`USTF_OFS_STATUS);
    apb(1'b1, `USTF_OFS_DATA, 32'h0000_0055);
    chk("txdata", {tx_full, tx_data}, 32'h0000_0155);
    rd(`USTF_OFS_STATUS);
    chk("tc_clr", rv, 32'h0000_0000);
    busy <= 1'b1;
    tx_load <= 1'b1;
    step(1);
    tx_load <= 1'b0;
    step(2);
    rd(`USTF_OFS_STATUS);
    chk("tc_busy", rv, 32'h0000_0080);
    busy <= 1'b0;
    step(2);
    rd(`USTF_OFS_STATUS);
    chk("tc_set", rv, 32'h0000_00C0);
    apb(1'b1, `USTF_OFS_CTRL2, 32'h0000_0008);
    rd(`USTF_OFS_STATUS);
    chk("tc_pre", rv, 32'h0000_0080);
    busy <= 1'b1;
    step(2);
    busy <= 1'b0;
    step(2);
    rd(`USTF_OFS_STATUS);
    apb(1'b1, `USTF_OFS_CTRL2, 32'h0000_0009);
    chk("brk", tx_brk, 32'h0000_0001);
    rd(`USTF_OFS_STATUS);
    chk("tc_brk", rv, 32'h0000_0080);
    busy <= 1'b1;
    step(2);
    busy <= 1'b0;
    step(2);
    // Last read saw the flag clear, so this write must leave it set
    apb(1'b1, `USTF_OFS_DATA, 32'h0000_0066);
    rd(`USTF_OFS_STATUS);
    chk("tc_keep", rv, 32'h0000_0040);
  endtask
  task automatic t_rx;
    rx_data <= 8'hA5;
    ld;
    rd(`USTF_OFS_DATA);
    chk("rxdata", rv, 32'h0000_00A5);
    rd(`USTF_OFS_STATUS);
    chk("rx_buffer_full_flag_set", rv & 32'h30, 32'h0000_0020);
    rd(`USTF_OFS_DATA);
    rd(`USTF_OFS_STATUS);
    chk("rx_buffer_full_flag_clr", rv & 32'h30, 32'h0000_0000);
  endtask
  task automatic t_idle(input logic aft, input logic m);
    int n;
    n = m ? 11 : 10;
    apb(1'b1, `USTF_OFS_CTRL1, {27'h0, m, 1'b0, aft, 2'b00});
    ld;
    rx_start <= 1'b1;
    step(1);
    rx_start <= 1'b0;
    // Ticks before the stop bits must not count in after-stop mode
    if (aft) begin
      repeat (n - 1) tk;
      rx_stop <= 1'b1;
      step(1);
      rx_stop <= 1'b0;
    end
    repeat (n - 1) tk;
    // One low bit time restarts the count; the pin passes two flip-flops first
    rxd <= 1'b0;
    step(3);
    tk;
    rxd <= 1'b1;
    step(3);
    repeat (n - 1) tk;
    rd(`USTF_OFS_STATUS);
    chk("idle_early", rv & 32'h10, 32'h0000_0000);
    tk;
    step(2);
    rd(`USTF_OFS_STATUS);
    chk("idle_set", rv & 32'h10, 32'h0000_0010);
    rd(`USTF_OFS_DATA);
    repeat (n + 2) tk;
    rd(`USTF_OFS_STATUS);
    chk("idle_once", rv & 32'h30, 32'h0000_0000);
  endtask
  task automatic t_irq;
    apb(1'b1, `USTF_OFS_IRQ_MASK, 32'h0000_0000);
    rd(`USTF_OFS_IRQ_STAT);
    ld;
    step(2);
    chk("irq_masked", irq, 32'h0000_0000);
    apb(1'b1, `USTF_OFS_IRQ_MASK, 32'h0000_0002);
    step(2);
    chk("irq_on", irq, 32'h0000_0001);
    rd(`USTF_OFS_IRQ_MASK);
    chk("mask", rv, 32'h0000_0002);
    rd(`USTF_OFS_IRQ_STAT);
    chk("irq_stat", rv & 32'h2, 32'h0000_0002);
    step(2);
    chk("irq_off", irq, 32'h0000_0000);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    step(4);
    t_reset;
    t_tx;
    t_rx;
    for (int k = 0; k < 4; k++) begin
      t_idle(k[1], k[0]);
    end
    t_irq;
    conclude;
  end
endmodule // ustf_tb_top
`default_nettype wire
